/* hw/cal_regs_consts.vh */
`ifndef CAL_REGS_CONSTS_VH
`define CAL_REGS_CONSTS_VH
// register indices; byte address is four times the index
`define IDX_CONFIG 8'h13
`define IDX_OFFSET_HIGH 8'h14
`define IDX_OFFSET_LOW 8'h15
`define IDX_GAIN_HIGH 8'h16
`define IDX_GAIN_LOW 8'h17
`define IDX_APPLY 8'h20
`define IDX_STATUS 8'h21
// reset values
`define RST_CONFIG 16'h0000
`define RST_OFFSET_HIGH 16'h0000
`define RST_OFFSET_LOW 16'h0000
`define RST_GAIN_HIGH 16'h8000
`define RST_GAIN_LOW 16'h0000
`define RST_CORR24 24'h000000
`define RST_GAIN24 24'h800000
// field positions
`define PHASE_HI 15
`define PHASE_LO 6
`define HPOFF_BIT 2
`define MUX_HI 1
`define MUX_LO 0
`define LOWBYTE_HI 15
`define LOWBYTE_LO 8
// writable masks; zeros mark reserved bits
`define MASK_CONFIG 16'hffc7
`define MASK_FULL 16'hffff
`define MASK_LOW 16'hff00
// input selector codes
`define SEL_PINS 2'h0
`define SEL_SHORT 2'h1
`define SEL_POS_TEST 2'h2
`define SEL_NEG_TEST 2'h3
// correction arithmetic
`define GAIN_FRAC 23
`endif

/* hw/masked_word_reg.v */
`timescale 1ns/10ps
`include "cal_regs_consts.vh"
module masked_word_reg #(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter [15:0] WRITE_MASK = 16'hffff
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // write side
    input wire wr_en,
    input wire [1:0] wr_sel,
    input wire [15:0] wr_data,
    // stored value
    output reg [15:0] value_reg
);
    wire [15:0] lane_mask;
    wire [15:0] value_next;
    assign lane_mask = {{8{wr_sel[1]}}, {8{wr_sel[0]}}} & WRITE_MASK;
    // masked bits never change, so reserved bits stay zero
    assign value_next = (value_reg & ~lane_mask) | (wr_data & lane_mask);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            value_reg <= RESET_VALUE;
        end else if (wr_en) begin
            value_reg <= value_next;
        end
    end
endmodule

/* hw/corr_datapath.v */
`timescale 1ns/10ps
`include "cal_regs_consts.vh"
module corr_datapath #(
    parameter WIDTH = 24
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // corrections
    input wire [WIDTH-1:0] offset_corr,
    input wire [WIDTH-1:0] gain_corr,
    // sample stream
    input wire raw_valid,
    input wire [WIDTH-1:0] raw_sample,
    output reg cal_valid_reg,
    output reg [WIDTH-1:0] cal_sample_reg
);
    localparam [WIDTH:0] MAXP = {2'b00, {(WIDTH-1){1'b1}}};
    localparam [WIDTH:0] MINN = {2'b11, {(WIDTH-1){1'b0}}};
    wire signed [WIDTH:0] sum;
    wire signed [WIDTH:0] sat;
    wire signed [2*WIDTH+1:0] prod;
    wire signed [WIDTH+2:0] scaled;
    wire signed [WIDTH-1:0] clipped;
    // offset is signed, added before gain
    assign sum = {raw_sample[WIDTH-1], raw_sample} + {offset_corr[WIDTH-1], offset_corr};
    assign sat = sum;
    // gain is unsigned, 1.23 format: full scale just under 2.0
    assign prod = sat * $signed({1'b0, gain_corr});
    assign scaled = prod[`GAIN_FRAC+WIDTH+2:`GAIN_FRAC];
    // saturate instead of wrapping so overflow cannot flip sign
    assign clipped = (scaled > $signed({2'b00, MAXP})) ? MAXP[WIDTH-1:0] :
                     (scaled < $signed({MINN[WIDTH], MINN[WIDTH], MINN})) ?
                     MINN[WIDTH-1:0] : scaled[WIDTH-1:0];
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cal_valid_reg <= 1'b0;
            cal_sample_reg <= {WIDTH{1'b0}};
        end else begin
            cal_valid_reg <= raw_valid;
            cal_sample_reg <= clipped;
        end
    end
endmodule

/* hw/chan_two_cal_regs.v */
// Operation
// - config bits 15:6 hold signed ten-bit phase delay, reset zero
// - reserved config bits 5:3 and low-word bits 7:0 read zero
// - config bit 2 forces highpass off; zero defers to global setting
// - config bits 1:0 pick pins, shorted, positive or negative test
// - offset high word holds offset bits 23:8, reset zero
// - offset low word upper byte holds offset bits 7:0, reset zero
// - assembled offset is signed two's complement
// - gain high word holds gain bits 23:8
// - gain low word upper byte holds gain bits 7:0, reset zero
// - gain is unsigned from 0.0 to just below 2.0
// - gain high resets to 8000, gain low resets to zero
`timescale 1ns/10ps
`include "cal_regs_consts.vh"
module chan_two_cal_regs #(
    parameter SAMPLE_WIDTH = 24
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire wb_err_o,
    // global highpass setting, from the device-wide register
    input wire [3:0] global_highpass_setting,
    // channel controls
    output reg [9:0] chan_two_phase_delay,
    output reg chan_two_highpass_off,
    output reg chan_two_highpass_on,
    output reg [1:0] chan_two_input_select,
    output reg chan_two_pos_input,
    output reg chan_two_neg_input,
    output reg chan_two_inputs_shorted,
    output reg [SAMPLE_WIDTH-1:0] offset_corr_active,
    output reg [SAMPLE_WIDTH-1:0] gain_corr_active,
    // sample stream
    input wire raw_valid,
    input wire [SAMPLE_WIDTH-1:0] raw_sample,
    output wire cal_valid,
    output wire [SAMPLE_WIDTH-1:0] cal_sample
);
    localparam NREG = 5;
    wire req;
    wire [7:0] idx;
    wire aligned;
    reg hit;
    reg [NREG-1:0] wr_vec;
    reg [31:0] rd_mux;
    wire [15:0] word_val [0:NREG-1];
    wire [15:0] cfg_w;
    wire [15:0] ofh_w;
    wire [15:0] ofl_w;
    wire [15:0] gnh_w;
    wire [15:0] gnl_w;
    reg offset_pending_reg;
    reg offset_pending_next;
    reg gain_pending_reg;
    reg gain_pending_next;
    reg apply_pulse;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx = wb_adr_i[9:2];
    assign aligned = (wb_adr_i[1:0] == 2'h0);
    assign wb_err_o = 1'b0;

    // one-hot write enables from the decoded index
    always @* begin
        wr_vec = {NREG{1'b0}};
        hit = 1'b0;
        apply_pulse = 1'b0;
        if (req && aligned) begin
            case (idx)
                `IDX_CONFIG: begin
                    hit = 1'b1;
                    wr_vec[0] = wb_we_i;
                end
                `IDX_OFFSET_HIGH: begin
                    hit = 1'b1;
                    wr_vec[1] = wb_we_i;
                end
                `IDX_OFFSET_LOW: begin
                    hit = 1'b1;
                    wr_vec[2] = wb_we_i;
                end
                `IDX_GAIN_HIGH: begin
                    hit = 1'b1;
                    wr_vec[3] = wb_we_i;
                end
                `IDX_GAIN_LOW: begin
                    hit = 1'b1;
                    wr_vec[4] = wb_we_i;
                end
                `IDX_APPLY: begin
                    hit = 1'b1;
                    apply_pulse = wb_we_i & wb_sel_i[0] & wb_dat_i[0];
                end
                `IDX_STATUS: begin
                    hit = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1) begin : g_word
            localparam [15:0] RV = (gi == 3) ? `RST_GAIN_HIGH : 16'h0000;
            localparam [15:0] WM = (gi == 0) ? `MASK_CONFIG :
                                   ((gi == 2) || (gi == 4)) ? `MASK_LOW : `MASK_FULL;
            // reset values: config/offset zero, gain high 8000
            masked_word_reg #(
                .RESET_VALUE(RV),
                .WRITE_MASK(WM)
            ) u_word (
                .clk(clk),
                .resetn(resetn),
                .wr_en(wr_vec[gi]),
                .wr_sel(wb_sel_i[1:0]),
                .wr_data(wb_dat_i[15:0]),
                .value_reg(word_val[gi])
            );
        end
    endgenerate

    assign cfg_w = word_val[0];
    assign ofh_w = word_val[1];
    assign ofl_w = word_val[2];
    assign gnh_w = word_val[3];
    assign gnl_w = word_val[4];

    // read mux; narrow words sit in the low half, upper half reads zero
    always @* begin
        rd_mux = 32'h00000000;
        case (idx)
            `IDX_CONFIG: rd_mux = {16'h0000, cfg_w & `MASK_CONFIG};
            `IDX_OFFSET_HIGH: rd_mux = {16'h0000, ofh_w};
            `IDX_OFFSET_LOW: rd_mux = {16'h0000, ofl_w & `MASK_LOW};
            `IDX_GAIN_HIGH: rd_mux = {16'h0000, gnh_w};
            `IDX_GAIN_LOW: rd_mux = {16'h0000, gnl_w & `MASK_LOW};
            `IDX_STATUS: rd_mux = {30'h0, gain_pending_reg, offset_pending_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // single-cycle ack; unmapped addresses ack and read zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && hit && !wb_we_i) ? rd_mux : 32'h00000000;
        end
    end

    // pending marks a half-written pair; the live value moves only when
    // the low word lands or apply is written, so the high word must be written first
    always @* begin
        offset_pending_next = offset_pending_reg;
        gain_pending_next = gain_pending_reg;
        if (wr_vec[1]) begin
            offset_pending_next = 1'b1;
        end
        if (wr_vec[2] || apply_pulse) begin
            offset_pending_next = 1'b0;
        end
        if (wr_vec[3]) begin
            gain_pending_next = 1'b1;
        end
        if (wr_vec[4] || apply_pulse) begin
            gain_pending_next = 1'b0;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            offset_pending_reg <= 1'b0;
            gain_pending_reg <= 1'b0;
            offset_corr_active <= `RST_CORR24;
            gain_corr_active <= `RST_GAIN24;
        end else begin
            offset_pending_reg <= offset_pending_next;
            gain_pending_reg <= gain_pending_next;
            // high word bits 23:8, low upper byte bits 7:0
            if (wr_vec[2]) begin
                offset_corr_active <= {ofh_w, wb_dat_i[`LOWBYTE_HI:`LOWBYTE_LO]};
            end else if (apply_pulse) begin
                offset_corr_active <= {ofh_w, ofl_w[`LOWBYTE_HI:`LOWBYTE_LO]};
            end
            if (wr_vec[4]) begin
                gain_corr_active <= {gnh_w, wb_dat_i[`LOWBYTE_HI:`LOWBYTE_LO]};
            end else if (apply_pulse) begin
                gain_corr_active <= {gnh_w, gnl_w[`LOWBYTE_HI:`LOWBYTE_LO]};
            end
        end
    end

    // decoded channel controls, registered
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_two_phase_delay <= 10'h000;
            chan_two_highpass_off <= 1'b0;
            chan_two_highpass_on <= 1'b0;
            chan_two_input_select <= `SEL_PINS;
            chan_two_pos_input <= 1'b0;
            chan_two_neg_input <= 1'b0;
            chan_two_inputs_shorted <= 1'b0;
        end else begin
            // kept as raw two's complement bits
            chan_two_phase_delay <= cfg_w[`PHASE_HI:`PHASE_LO];
            chan_two_highpass_off <= cfg_w[`HPOFF_BIT];
            // any nonzero global setting enables the filter unless forced off
            chan_two_highpass_on <= ~cfg_w[`HPOFF_BIT] & (|global_highpass_setting);
            chan_two_input_select <= cfg_w[`MUX_HI:`MUX_LO];
            chan_two_pos_input <= (cfg_w[`MUX_HI:`MUX_LO] == `SEL_PINS);
            chan_two_neg_input <= (cfg_w[`MUX_HI:`MUX_LO] == `SEL_PINS);
            chan_two_inputs_shorted <= (cfg_w[`MUX_HI:`MUX_LO] == `SEL_SHORT);
        end
    end

    corr_datapath #(
        .WIDTH(SAMPLE_WIDTH)
    ) u_corr (
        .clk(clk),
        .resetn(resetn),
        .offset_corr(offset_corr_active),
        .gain_corr(gain_corr_active),
        .raw_valid(raw_valid),
        .raw_sample(raw_sample),
        .cal_valid_reg(cal_valid),
        .cal_sample_reg(cal_sample)
    );
endmodule

/* verif/chan_two_cal_regs_properties.sv */
`timescale 1ns/10ps
`include "cal_regs_consts.vh"
module chan_two_cal_regs_properties #(
    parameter SAMPLE_WIDTH = 24
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    // channel controls
    input wire [3:0] global_highpass_setting,
    input wire [9:0] chan_two_phase_delay,
    input wire chan_two_highpass_off,
    input wire chan_two_highpass_on,
    input wire [1:0] chan_two_input_select,
    input wire chan_two_pos_input,
    input wire chan_two_neg_input,
    input wire chan_two_inputs_shorted,
    input wire [SAMPLE_WIDTH-1:0] offset_corr_active,
    input wire [SAMPLE_WIDTH-1:0] gain_corr_active,
    // samples
    input wire raw_valid,
    input wire [SAMPLE_WIDTH-1:0] raw_sample,
    input wire cal_valid,
    input wire [SAMPLE_WIDTH-1:0] cal_sample
);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_ack = wb_ack_o && !wb_we_i;
    wire [7:0] idx = wb_adr_i[9:2];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_answer_a: assert property (take |=> wb_ack_o) else $error("ack missing");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    cfg_reserved_a: assert property (rd_ack && idx == `IDX_CONFIG |-> wb_dat_o[5:3] == 3'h0)
        else $error("config reserved bits set");
    low_reserved_a: assert property (rd_ack &&
        (idx == `IDX_OFFSET_LOW || idx == `IDX_GAIN_LOW) |-> wb_dat_o[7:0] == 8'h0)
        else $error("low reserved byte set");
    phase_follow_a: assert property (take && wb_we_i && idx == `IDX_CONFIG &&
        wb_sel_i[1:0] == 2'h3 |-> ##3 chan_two_phase_delay == $past(wb_dat_i[15:6], 3))
        else $error("phase not written");
    highpass_gate_a: assert property (1'b1 |=> chan_two_highpass_on ==
        (!chan_two_highpass_off && $past(global_highpass_setting) != 4'h0)) else $error("highpass");
    select_decode_a: assert property (1'b1 |=>
        chan_two_inputs_shorted == (chan_two_input_select == `SEL_SHORT) &&
        chan_two_pos_input == (chan_two_input_select == `SEL_PINS)) else $error("select decode");
    offset_live_a: assert property (take && wb_we_i &&
        idx == `IDX_OFFSET_LOW && wb_sel_i[1]
        |=> offset_corr_active[7:0] == $past(wb_dat_i[15:8])) else $error("offset not live");
    gain_live_a: assert property (take && wb_we_i && idx == `IDX_GAIN_LOW && wb_sel_i[1]
        |=> gain_corr_active[7:0] == $past(wb_dat_i[15:8])) else $error("gain not live");
    gain_reset_a: assert property ($rose(resetn) |-> gain_corr_active == 24'h800000
        && offset_corr_active == 24'h0) else $error("correction reset value");
    cal_timing_a: assert property (1'b1 |=> cal_valid == $past(raw_valid))
        else $error("sample timing");
    err_idle_a: assert property (!wb_err_o) else $error("error response raised");
endmodule
bind chan_two_cal_regs chan_two_cal_regs_properties #(.SAMPLE_WIDTH(SAMPLE_WIDTH))
    chan_two_cal_regs_properties_inst (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .global_highpass_setting(global_highpass_setting),
    .chan_two_phase_delay(chan_two_phase_delay), .chan_two_highpass_off(chan_two_highpass_off),
    .chan_two_highpass_on(chan_two_highpass_on), .chan_two_input_select(chan_two_input_select),
    .chan_two_pos_input(chan_two_pos_input), .chan_two_neg_input(chan_two_neg_input),
    .chan_two_inputs_shorted(chan_two_inputs_shorted), .offset_corr_active(offset_corr_active),
    .gain_corr_active(gain_corr_active), .raw_valid(raw_valid), .raw_sample(raw_sample),
    .cal_valid(cal_valid), .cal_sample(cal_sample));

/* verif/tb_chan_two_cal_regs.sv */
`timescale 1ns/10ps
`include "cal_regs_consts.vh"
module tb_chan_two_cal_regs;
    reg clk, resetn, cyc, stb, we, raw_valid;
    reg [9:0] adr;
    reg [3:0] sel, ghp;
    reg [31:0] dat, q;
    reg [23:0] raw, o, g;
    reg [15:0] rnd;
    reg [15:0] w [0:4];
    reg [15:0] mask [0:4];
    wire [31:0] dat_o;
    wire ack, hp_off, hp_on, pos_in, neg_in, shorted, cal_valid;
    wire [9:0] phase;
    wire [1:0] isel;
    wire [23:0] off_act, gain_act, cal;
    integer err_count, num_checks, i, k;
    chan_two_cal_regs #(.SAMPLE_WIDTH(24)) chan_two_cal_regs_inst (.clk(clk), .resetn(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(),
        .global_highpass_setting(ghp), .chan_two_phase_delay(phase),
        .chan_two_highpass_off(hp_off), .chan_two_highpass_on(hp_on),
        .chan_two_input_select(isel), .chan_two_pos_input(pos_in), .chan_two_neg_input(neg_in),
        .chan_two_inputs_shorted(shorted), .offset_corr_active(off_act),
        .gain_corr_active(gain_act), .raw_valid(raw_valid), .raw_sample(raw),
        .cal_valid(cal_valid), .cal_sample(cal));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // exact only for even sums, so truncation and flooring agree
    function [23:0] exp_cal(input [23:0] r, input [23:0] ov, input [23:0] gv);
        reg signed [63:0] s;
        begin
            s = ($signed({{40{r[23]}}, r}) + $signed({{40{ov[23]}}, ov})) * $signed({40'h0, gv});
            s = s >>> 23;
            if (s > 64'sh7fffff) exp_cal = 24'h7fffff;
            else if (s < -64'sh800000) exp_cal = 24'h800000;
            else exp_cal = s[23:0];
        end
    endfunction
    task check(input [8*12-1:0] nm, input [31:0] e, input [31:0] v);
        begin
            num_checks = num_checks + 1;
            if (v !== e) begin
                err_count = err_count + 1;
                $display("unexpected %0s expected %h seen %h", nm, e, v);
            end
        end
    endtask
    task xfer(input [7:0] ix, input wr, input [15:0] d);
        integer n;
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= wr;
            adr <= {ix, 2'h0};
            dat <= {16'h0, d};
            n = 0;
            @(posedge clk);
            while (ack !== 1'b1 && n < 20) begin
                @(posedge clk);
                n = n + 1;
            end
            check("ack", 1, ack);
            q = dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        err_count = err_count + 1;
        final_report;
    end
    initial begin
        {resetn, cyc, stb, we, raw_valid, adr, dat, raw, ghp} = 0;
        sel = 4'hf;
        rnd = 16'h002d;
        err_count = 0;
        num_checks = 0;
        w[0] = `RST_CONFIG; w[1] = `RST_OFFSET_HIGH; w[2] = `RST_OFFSET_LOW;
        w[3] = `RST_GAIN_HIGH; w[4] = `RST_GAIN_LOW;
        mask[0] = `MASK_CONFIG; mask[1] = `MASK_FULL; mask[2] = `MASK_LOW;
        mask[3] = `MASK_FULL; mask[4] = `MASK_LOW;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (k = 0; k < 21; k = k + 1) begin
            // first pass reads reset values, later passes random words
            for (i = 0; i < 5 && k > 0; i = i + 1) begin
                rnd = lfsr(rnd);
                w[i] = rnd;
                xfer(`IDX_CONFIG + i[7:0], 1'b1, rnd);
            end
            for (i = 0; i < 5; i = i + 1) begin
                xfer(`IDX_CONFIG + i[7:0], 1'b0, 16'h0);
                check("readback", {16'h0, w[i] & mask[i]}, q);
            end
            check("offset_live", {w[1], w[2][15:8]}, off_act);
            check("gain_live", {w[3], w[4][15:8]}, gain_act);
        end
        $display("test registers done");
        for (i = 0; i < 8; i = i + 1) begin
            rnd = lfsr(rnd);
            @(posedge clk);
            ghp <= rnd[4] ? (rnd[3:0] | 4'h1) : 4'h0;
            xfer(`IDX_CONFIG, 1'b1, {rnd[15:6], 3'h7, i[2], i[1:0]});
            repeat (3) @(posedge clk);
            #1;
            check("phase", rnd[15:6], phase);
            check("hp_off", i[2], hp_off);
            check("hp_on", !i[2] && ghp != 4'h0, hp_on);
            check("select", i[1:0], isel);
            check("pins", {2{i[1:0] == 2'h0}}, {pos_in, neg_in});
            check("shorted", i[1:0] == 2'h1, shorted);
        end
        xfer(8'h30, 1'b1, 16'hffff);
        xfer(8'h30, 1'b0, 16'h0);
        check("unmapped", 0, q);
        $display("test config done");
        for (k = 0; k < 12; k = k + 1) begin
            rnd = lfsr(rnd);
            o[23:8] = rnd;
            // drive both saturation limits: full-scale raw, same-sign offset, gain 1.5
            if (k == 2 || k == 5) o[23] = (k == 5);
            xfer(`IDX_OFFSET_HIGH, 1'b1, o[23:8]);
            rnd = lfsr(rnd);
            xfer(`IDX_OFFSET_LOW, 1'b1, rnd & 16'hfe00);
            o[7:0] = rnd[15:8] & 8'hfe;
            g = {(k % 3 == 0) ? 8'h40 : (k % 3 == 1) ? 8'h80 : 8'hc0, 16'h0};
            xfer(`IDX_GAIN_HIGH, 1'b1, g[23:8]);
            xfer(`IDX_GAIN_LOW, 1'b1, 16'h0);
            rnd = lfsr(rnd);
            @(posedge clk);
            raw_valid <= 1'b1;
            raw <= (k == 0 || k == 2) ? 24'h7ffffe : (k == 5) ? 24'h800000 :
                   {rnd, rnd[7:1], 1'b0};
            @(posedge clk);
            raw_valid <= 1'b0;
            #1;
            check("cal_valid", 1, cal_valid);
            check("cal_sample", exp_cal(raw, o, g), cal);
        end
        $display("test samples done");
        // high words alone leave live values; apply reloads from stored words
        xfer(`IDX_OFFSET_HIGH, 1'b1, 16'h1234);
        xfer(`IDX_GAIN_HIGH, 1'b1, 16'h4321);
        xfer(`IDX_STATUS, 1'b0, 16'h0);
        check("pending", 3, q);
        check("offset_held", o, off_act);
        check("gain_held", g, gain_act);
        xfer(`IDX_APPLY, 1'b1, 16'h0001);
        xfer(`IDX_STATUS, 1'b0, 16'h0);
        check("pending", 0, q);
        check("offset_apply", {16'h1234, o[7:0]}, off_act);
        check("gain_apply", 24'h432100, gain_act);
        // reset in mid-run
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("rst_ack", 0, ack);
        check("rst_gain", `RST_GAIN24, gain_act);
        check("rst_offset", `RST_CORR24, off_act);
        check("rst_phase", 0, phase);
        @(posedge clk);
        resetn <= 1'b1;
        xfer(`IDX_GAIN_HIGH, 1'b0, 16'h0);
        check("rst_readback", `RST_GAIN_HIGH, q);
        xfer(`IDX_CONFIG, 1'b0, 16'h0);
        check("rst_config", `RST_CONFIG, q);
        $display("test apply and reset done");
        final_report;
    end
endmodule
